// ### rtl/ibf_ctrl.sv
// Single channel master with bus-fault detection and reset sequencing
`timescale 1ns/10ps
`include "ibf_cfg.svh"

//Contract
// - SCL low for timeout value is error
// - Recovery request ignored on SCL-low error
// - Misplaced START/STOP detection after ready reads zero
// - Monitor always, except own driven transitions (code monitors only in the IBF_BIT and IBF_ACK states)
// - START/STOP inside byte or ack is error
// - On error release lines, flag, status bit
// - After reset: oscillator wait, registers, memory zeroed
// - Writes ignored during init, reads answered
// - Reset pin low minimum width resets globally
// - A5h then 5Ah globally resets by software
// - Pin and software reset act like power-on
// - A5h then 5Ah resets the channel
// - Start only with both lines high
// - Data changes only while clock low
// - START falls, STOP rises, clock high
// - Eight bits plus one master-clocked ack
// - Last received byte left unacknowledged
// - Recovery request emits extra clock pulses
module ibf_ctrl (
	// Clock and power-on reset
	input  wire logic                 ref_clk,
	input  wire logic                 nrst,
	// Reset pin, active low
	input  wire logic                 rst_pin_n,
	// Parallel-port writes
	input  wire ibf_pkg::ibf_pwr_type pwr,
	// Transfer command and configuration
	input  wire ibf_pkg::ibf_cmd_type cmd,
	input  wire logic [15:0]          cfg_timeout,
	input  wire logic                 bus_recovery_request,
	// Serial pins
	input  wire logic                 scl_i,
	input  wire logic                 sda_i,
	output ibf_pkg::ibf_pins_type     pins,
	// Readable state
	output logic [7:0]                controller_ready_reg,
	output logic [7:0]                channel_status_reg,
	output logic                      irq_flag,
	output logic                      busy,
	output logic [7:0]                rx_data
);

	typedef struct packed {
		ibf_pkg::ibf_state_type st;
		logic [1:0]             ph;
		logic [7:0]             qcnt;
		logic [3:0]             bcnt;
		logic [7:0]             shreg;
		ibf_pkg::ibf_cmd_type   op;
		ibf_pkg::ibf_pins_type  pins;
		logic [15:0]            tcnt;
		logic                   sda_p;
		logic                   scl_p;
		logic [7:0]             status;
		logic                   irq;
		logic                   in_init;
		logic                   mem_clr;
		logic [11:0]            icnt;
		logic [2:0]             midx;
		logic [7:0]             pin_cnt;
		logic [7:0]             ready;
		logic                   busy;
		logic [`IBF_MEM_DEPTH-1:0][7:0] mem;
	} ibf_ctrl_type;

	ibf_ctrl_type s_q;
	ibf_ctrl_type s_d;

	logic [1:0] key_fire;
	logic       wr_ok;
	logic       start_seen;
	logic       stop_seen;
	logic       qtr_end;

	// Drive both lines: low when the bit is zero, released when one
	function automatic ibf_pkg::ibf_pins_type drive(input logic scl, input logic sda);
		drive.scl_o  = 1'b0;
		drive.sda_o  = 1'b0;
		drive.scl_oe = !scl;
		drive.sda_oe = !sda;
	endfunction : drive

	// Writes are dropped while initialising
	// write gate
	assign wr_ok = pwr.stb && !s_q.in_init;

	// One unlock detector per reset register
	// global and channel keys
	generate
		for (genvar k = 0; k < 2; k++) begin : g_key
			ibf_key_seq u_key (
				.ref_clk (ref_clk),
				.nrst    (nrst),
				.wr_stb  (wr_ok && (pwr.sel == ((k == 0) ? ibf_pkg::IBF_SEL_GLOBAL_RST
				                                         : ibf_pkg::IBF_SEL_CHAN_RST))),
				.wr_data (pwr.data),
				.fire    (key_fire[k])
			);
		end
	endgenerate

	// Line conditions seen with clock high on both samples
	// start stop
	assign start_seen = scl_i && s_q.scl_p && s_q.sda_p && !sda_i;
	assign stop_seen  = scl_i && s_q.scl_p && !s_q.sda_p && sda_i;
	assign qtr_end    = (s_q.qcnt == 8'(`IBF_QTR_CYC - 1));

	// Next-state logic
	always_comb begin
		s_d       = s_q;
		s_d.sda_p = sda_i;
		s_d.scl_p = scl_i;

		// Quarter-period timer; stalls in the high phase while a slave stretches.
		// Only a released clock can be stretched: our own low drive must not stall it.
		if (s_q.st != ibf_pkg::IBF_IDLE) begin
			if (qtr_end) begin
				s_d.qcnt = '0;
			end else if (!(s_q.ph == 2'h2 && !scl_i && !s_q.pins.scl_oe)) begin
				s_d.qcnt = s_q.qcnt + 8'h01;
			end
		end

		unique case (s_q.st)
			ibf_pkg::IBF_IDLE: begin
				s_d.pins = drive(1'b1, 1'b1);
				s_d.ph   = '0;
				s_d.qcnt = '0;
				if (cmd.go && !s_q.in_init) begin
					s_d.op = cmd;
					if (cmd.start && scl_i && sda_i) begin
						s_d.st = ibf_pkg::IBF_START;
					end else if (!cmd.start) begin
						s_d.st   = ibf_pkg::IBF_BIT;
						s_d.bcnt = '0;
					end
					s_d.shreg = cmd.data;
					s_d.status[`IBF_ST_DONE] = 1'b0;
				end else if (bus_recovery_request && !s_q.in_init) begin
					if (!s_q.status[`IBF_ST_SCL_LOW] && scl_i) begin
						s_d.st   = ibf_pkg::IBF_RECOV;
						s_d.bcnt = '0;
					end
				end
			end
			ibf_pkg::IBF_START: begin
				unique case (s_q.ph)
					2'h0: s_d.pins = drive(1'b1, 1'b1);
					2'h1: s_d.pins = drive(1'b1, 1'b0);
					default: s_d.pins = drive(1'b0, 1'b0);
				endcase
				if (qtr_end) begin
					s_d.ph = s_q.ph + 2'h1;
					if (s_q.ph == 2'h3) begin
						s_d.st   = ibf_pkg::IBF_BIT;
						s_d.bcnt = '0;
					end
				end
			end
			ibf_pkg::IBF_BIT: begin
				s_d.pins = drive(s_q.ph[1], s_q.op.rd || s_q.shreg[7]);
				if (qtr_end) begin
					s_d.ph = s_q.ph + 2'h1;
					if (s_q.ph == 2'h3) begin
						s_d.shreg = {s_q.shreg[6:0], sda_i};
						s_d.bcnt  = s_q.bcnt + 4'h1;
						if (s_q.bcnt == `IBF_BYTE_BITS - 4'h1) begin
							s_d.st = ibf_pkg::IBF_ACK;
						end
					end
				end
			end
			ibf_pkg::IBF_ACK: begin
				s_d.pins = drive(s_q.ph[1], !(s_q.op.rd && !s_q.op.nack));
				if (qtr_end) begin
					s_d.ph = s_q.ph + 2'h1;
					if (s_q.ph == 2'h3) begin
						if (s_q.op.rd) begin
							s_d.mem = {s_q.mem[`IBF_MEM_DEPTH-2:0], s_q.shreg};
						end else begin
							s_d.status[`IBF_ST_NACK] = sda_i;
						end
						s_d.status[`IBF_ST_DONE] = 1'b1;
						s_d.st = s_q.op.stop ? ibf_pkg::IBF_STOP : ibf_pkg::IBF_IDLE;
					end
				end
			end
			ibf_pkg::IBF_STOP: begin
				unique case (s_q.ph)
					2'h0: s_d.pins = drive(1'b0, 1'b0);
					2'h1, 2'h2: s_d.pins = drive(1'b1, 1'b0);
					default: s_d.pins = drive(1'b1, 1'b1);
				endcase
				if (qtr_end) begin
					s_d.ph = s_q.ph + 2'h1;
					if (s_q.ph == 2'h3) begin
						s_d.st = ibf_pkg::IBF_IDLE;
					end
				end
			end
			ibf_pkg::IBF_RECOV: begin
				// Data stays released so a stuck slave can let go
				s_d.pins = drive(s_q.ph[1], 1'b1);
				if (qtr_end) begin
					s_d.ph = s_q.ph + 2'h1;
					if (s_q.ph == 2'h3) begin
						s_d.bcnt = s_q.bcnt + 4'h1;
						if (s_q.bcnt == `IBF_RECOV_PULSES - 4'h1) begin
							s_d.st = ibf_pkg::IBF_IDLE;
						end
					end
				end
			end
			default: begin
				s_d.st = ibf_pkg::IBF_IDLE;
			end
		endcase

		// Clock-low watchdog counts only while the line is low
		// scl timeout
		if (scl_i) begin
			s_d.tcnt = '0;
		end else if (s_q.tcnt != cfg_timeout) begin
			s_d.tcnt = s_q.tcnt + 16'h0001;
		end
		if (!scl_i && cfg_timeout != '0 && s_q.tcnt == cfg_timeout - 16'h0001) begin
			s_d.status[`IBF_ST_SCL_LOW] = 1'b1;
			s_d.irq  = 1'b1;
			s_d.st   = ibf_pkg::IBF_IDLE;
			s_d.pins = drive(1'b1, 1'b1);
		end

		// Misplaced condition: only inside a byte or ack, never our own edges
		// armed when ready
		if ((s_q.ready == `IBF_READY_OK) && (start_seen || stop_seen)
			&& (s_q.st == ibf_pkg::IBF_BIT || s_q.st == ibf_pkg::IBF_ACK)) begin
			s_d.status[`IBF_ST_SSE] = 1'b1;
			s_d.irq  = 1'b1;
			s_d.st   = ibf_pkg::IBF_IDLE;
			s_d.pins = drive(1'b1, 1'b1);
		end

		// Write-one-to-clear; a flag set in the same cycle survives
		if (wr_ok && pwr.sel == ibf_pkg::IBF_SEL_STATUS_CLR) begin
			s_d.status = s_d.status & ~(pwr.data & ~(s_d.status ^ s_q.status));
			s_d.irq    = s_d.status[`IBF_ST_SSE] || s_d.status[`IBF_ST_SCL_LOW];
		end

		// Channel reset returns the engine and flags to power-up values
		// channel reset
		if (key_fire[1]) begin
			s_d.st     = ibf_pkg::IBF_IDLE;
			s_d.ph     = '0;
			s_d.qcnt   = '0;
			s_d.bcnt   = '0;
			s_d.shreg  = '0;
			s_d.op     = '0;
			s_d.status = '0;
			s_d.irq    = 1'b0;
			s_d.pins   = drive(1'b1, 1'b1);
		end

		// Initialisation: oscillator settle, then zero the buffer by index
		// init sequence
		if (s_q.in_init) begin
			s_d.ready = `IBF_READY_BUSY;
			if (!s_q.mem_clr) begin
				s_d.icnt = s_q.icnt + 12'h001;
				if (s_q.icnt == 12'(`IBF_OSC_CYC - 1)) begin
					s_d.mem_clr = 1'b1;
				end
			end else begin
				s_d.mem[s_q.midx] = '0;
				s_d.midx = s_q.midx + 3'h1;
				if (s_q.midx == `IBF_MEM_LAST) begin
					s_d.in_init = 1'b0;
					s_d.ready   = `IBF_READY_OK;
				end
			end
		end

		// Pin reset must stay low for the minimum width before it acts
		// pin width
		if (rst_pin_n) begin
			s_d.pin_cnt = '0;
		end else if (s_q.pin_cnt != 8'(`IBF_RSTW_CYC)) begin
			s_d.pin_cnt = s_q.pin_cnt + 8'h01;
		end

		// Pin and software reset restart everything as at power-up
		// global reset
		if (key_fire[0] || s_d.pin_cnt == 8'(`IBF_RSTW_CYC)) begin
			s_d         = '0;
			s_d.sda_p   = sda_i;
			s_d.scl_p   = scl_i;
			s_d.pin_cnt = s_q.pin_cnt;
			s_d.in_init = 1'b1;
			s_d.ready   = `IBF_READY_BUSY;
			s_d.mem     = s_q.mem;
			s_d.pins    = drive(1'b1, 1'b1);
		end

		// Busy is registered so the port comes straight from a flip-flop
		s_d.busy = (s_d.st != ibf_pkg::IBF_IDLE);
	end

	// State register; power-on reset enters the init phase
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			s_q         <= '0;
			s_q.in_init <= 1'b1;
			s_q.ready   <= `IBF_READY_BUSY;
			s_q.sda_p   <= 1'b1;
			s_q.scl_p   <= 1'b1;
			s_q.pins    <= 4'h0;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs come straight from the state register
	assign pins                 = s_q.pins;
	assign controller_ready_reg = s_q.ready;
	assign channel_status_reg   = s_q.status;
	assign irq_flag             = s_q.irq;
	assign busy                 = s_q.busy;
	assign rx_data              = s_q.mem[0];

endmodule : ibf_ctrl

// ### common/ibf_cfg.svh
// Constants for the bus-fault and reset control block
`ifndef IBF_CFG_SVH
`define IBF_CFG_SVH

// Clock and serial timing
`define IBF_CLK_NS        4
`define IBF_QTR_NS        250
`define IBF_QTR_CYC       (`IBF_QTR_NS / `IBF_CLK_NS)
`define IBF_RSTW_NS       100
`define IBF_RSTW_CYC      ((`IBF_RSTW_NS + `IBF_CLK_NS - 1) / `IBF_CLK_NS)
`define IBF_OSC_NS        2000
`define IBF_OSC_CYC       ((`IBF_OSC_NS + `IBF_CLK_NS - 1) / `IBF_CLK_NS)

// Reset key bytes and ready codes
`define IBF_KEY_FIRST     8'ha5
`define IBF_KEY_SECOND    8'h5a
`define IBF_READY_OK      8'h00
`define IBF_READY_BUSY    8'hff

// Sizes
`define IBF_BYTE_BITS     4'h8
`define IBF_RECOV_PULSES  4'h9
`define IBF_MEM_DEPTH     8
`define IBF_MEM_LAST      3'h7

// Status bit positions
`define IBF_ST_SSE        0
`define IBF_ST_SCL_LOW    1
`define IBF_ST_NACK       2
`define IBF_ST_DONE       3

`endif

// ### common/ibf_pkg.sv
// Types shared by the bus-fault and reset control block
package ibf_pkg;

	// Target of a parallel-port write
	typedef enum logic [1:0] {
		IBF_SEL_NONE,
		IBF_SEL_GLOBAL_RST,
		IBF_SEL_CHAN_RST,
		IBF_SEL_STATUS_CLR
	} ibf_sel_type;

	// One parallel-port write
	typedef struct packed {
		logic        stb;
		ibf_sel_type sel;
		logic [7:0]  data;
	} ibf_pwr_type;

	// One byte transfer command
	typedef struct packed {
		logic       go;
		logic       start;
		logic       stop;
		logic       rd;
		logic       nack;
		logic [7:0] data;
	} ibf_cmd_type;

	// Serial engine states
	typedef enum logic [2:0] {
		IBF_IDLE,
		IBF_START,
		IBF_BIT,
		IBF_ACK,
		IBF_STOP,
		IBF_RECOV
	} ibf_state_type;

	// Open-drain pin drive
	typedef struct packed {
		logic scl_o;
		logic scl_oe;
		logic sda_o;
		logic sda_oe;
	} ibf_pins_type;

endpackage : ibf_pkg

// ### rtl/ibf_key_seq.sv
// Two-write unlock detector for a reset register
`timescale 1ns/10ps
`include "ibf_cfg.svh"

module ibf_key_seq (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       nrst,
	// Write to this register
	input  wire logic       wr_stb,
	input  wire logic [7:0] wr_data,
	// One-cycle reset request
	output logic            fire
);

	typedef struct packed {
		logic armed;
		logic fire;
	} ibf_key_type;

	ibf_key_type s_q;
	ibf_key_type s_d;

	// Any write after the first key either fires or disarms
	always_comb begin
		s_d      = s_q;
		s_d.fire = 1'b0;
		if (wr_stb) begin
			if (s_q.armed) begin
				s_d.armed = 1'b0;
				s_d.fire  = (wr_data == `IBF_KEY_SECOND);
			end else begin
				s_d.armed = (wr_data == `IBF_KEY_FIRST);
			end
		end
	end

	// State register
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign fire = s_q.fire;

endmodule : ibf_key_seq

// ### bench/ibf_ctrl_monitor.sv
// Assertion checker for the bus-fault and reset control block
`timescale 1ns/10ps

module ibf_ctrl_monitor (
	// Clock and resets
	input wire logic                  ref_clk,
	input wire logic                  nrst,
	input wire logic                  rst_pin_n,
	// Requests
	input wire ibf_pkg::ibf_pwr_type  pwr,
	input wire ibf_pkg::ibf_cmd_type  cmd,
	input wire logic                  bus_recovery_request,
	// Lines and state
	input wire logic                  scl_i,
	input wire logic                  sda_i,
	input wire ibf_pkg::ibf_pins_type pins,
	input wire logic [7:0]            controller_ready_reg,
	input wire logic [7:0]            channel_status_reg,
	input wire logic                  irq_flag,
	input wire logic                  busy
);
	logic [4:0] pin_low_q;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	// Saturating run length of the reset pin, so it never wraps
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			pin_low_q <= 5'h00;
		else if (rst_pin_n)
			pin_low_q <= 5'h00;
		else if (pin_low_q != 5'h1f)
			pin_low_q <= pin_low_q + 5'h01;
	end

	// Two back-to-back key writes to one target
	sequence s_key(s);
		pwr.stb && pwr.sel == s && pwr.data == 8'ha5 && controller_ready_reg == 8'h00
		##1 pwr.stb && pwr.sel == s && pwr.data == 8'h5a;
	endsequence

	property p_sse;
		$rose(channel_status_reg[0]) |-> irq_flag && !busy && !pins.scl_oe && !pins.sda_oe;
	endproperty
	a_sse: assert property (p_sse) else $error("misplaced condition not handled");
	property p_tmo;
		$rose(channel_status_reg[1]) |-> irq_flag && !pins.scl_oe && !pins.sda_oe;
	endproperty
	a_tmo: assert property (p_tmo) else $error("clock timeout not handled");
	property p_init;
		controller_ready_reg != 8'h00 |-> !busy && !pins.scl_oe && !pins.sda_oe;
	endproperty
	a_init: assert property (p_init) else $error("activity during init");
	property p_ready;
		controller_ready_reg == 8'h00 || controller_ready_reg == 8'hff;
	endproperty
	a_ready: assert property (p_ready) else $error("ready code invalid");
	property p_idle;
		$rose(busy) && $past(cmd.go) && $past(cmd.start) |-> $past(scl_i && sda_i);
	endproperty
	a_idle: assert property (p_idle) else $error("start on busy bus");
	property p_sda;
		$changed(pins.sda_oe) && busy && !pins.scl_oe && $past(!pins.scl_oe) |-> scl_i;
	endproperty
	a_sda: assert property (p_sda) else $error("data moved badly");
	property p_grst;
		s_key(ibf_pkg::IBF_SEL_GLOBAL_RST) |-> ##[1:3] controller_ready_reg == 8'hff;
	endproperty
	a_grst: assert property (p_grst) else $error("soft reset missed");
	property p_crst;
		s_key(ibf_pkg::IBF_SEL_CHAN_RST) |-> ##[1:3] channel_status_reg == 8'h00 && !busy;
	endproperty
	a_crst: assert property (p_crst) else $error("channel reset missed");
	property p_pin;
		pin_low_q == 5'h19 |-> ##[0:3] controller_ready_reg == 8'hff;
	endproperty
	a_pin: assert property (p_pin) else $error("pin reset missed");
	property p_norec;
		channel_status_reg[1] && bus_recovery_request && !busy |=> !busy;
	endproperty
	a_norec: assert property (p_norec) else $error("recovery ran");
endmodule : ibf_ctrl_monitor

bind ibf_ctrl ibf_ctrl_monitor u_mon (.ref_clk, .nrst, .rst_pin_n, .pwr, .cmd,
	.bus_recovery_request, .scl_i, .sda_i, .pins, .controller_ready_reg,
	.channel_status_reg, .irq_flag, .busy);

// ### bench/ibf_slave_model.sv
// Serial slave model: acknowledges, stretches the clock, forces a bad START
`timescale 1ns/10ps

module ibf_slave_model (
	// Clock
	input wire logic ref_clk,
	// Wired line levels
	input wire logic scl,
	input wire logic sda,
	// Fault commands
	input wire logic hold_scl,
	input wire logic glitch,
	// Open-drain pulls
	output logic     scl_low,
	output logic     sda_low
);
	logic       scl_q = 1'b1;
	logic       sda_q = 1'b1;
	logic [3:0] fall_n = 4'hf;
	logic       ack_q = 1'b0;
	logic       glt_q = 1'b0;

	// Count clock falls from each START
	always @(posedge ref_clk) begin
		scl_q <= scl;
		sda_q <= sda;
		if (scl && scl_q && sda_q && !sda)
			fall_n <= 4'h0;
		else if (scl_q && !scl && fall_n != 4'hf)
			fall_n <= fall_n + 4'h1;
		// ack held from the clock fall that starts the ack bit until the next fall
		if (scl_q && !scl)
			ack_q <= (fall_n == 4'h8);
		glt_q <= glitch && (scl || glt_q);
	end

	assign sda_low = ack_q || glt_q;
	assign scl_low = hold_scl;
endmodule : ibf_slave_model

// ### bench/ibf_ctrl_test.sv
// Self-checking bench for the bus-fault and reset control block
`timescale 1ns/10ps

module ibf_ctrl_test;
	logic                  ref_clk = 1'b0;
	logic                  nrst;
	logic                  rst_pin_n;
	ibf_pkg::ibf_pwr_type  pwr;
	ibf_pkg::ibf_cmd_type  cmd;
	logic [15:0]           cfg_timeout;
	logic                  bus_recovery_request;
	logic                  hold_scl;
	logic                  glitch;
	logic                  scl_low;
	logic                  sda_low;
	ibf_pkg::ibf_pins_type pins;
	logic [7:0]            controller_ready_reg;
	logic [7:0]            channel_status_reg;
	logic                  irq_flag;
	logic                  busy;
	logic [7:0]            rx_data;
	wire logic             scl_line = !(pins.scl_oe || scl_low);
	wire logic             sda_line = !(pins.sda_oe || sda_low);
	int                    bad_count = 0;
	int                    n_compared = 0;
	int                    cyc = 0;

	always #2 ref_clk = ~ref_clk;

	ibf_ctrl uut (.ref_clk, .nrst, .rst_pin_n, .pwr, .cmd, .cfg_timeout,
		.bus_recovery_request, .scl_i(scl_line), .sda_i(sda_line), .pins,
		.controller_ready_reg, .channel_status_reg, .irq_flag, .busy, .rx_data);
	ibf_slave_model slv (.ref_clk, .scl(scl_line), .sda(sda_line), .hold_scl,
		.glitch, .scl_low, .sda_low);

	task automatic give_verdict;
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Clock edges, settled a little after the edge
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick

	// Two back-to-back writes to one reset target
	task automatic key(input ibf_pkg::ibf_sel_type s, input logic [7:0] b2);
		@(posedge ref_clk) pwr <= '{1'b1, s, 8'ha5};
		@(posedge ref_clk) pwr <= '{1'b1, s, b2};
		@(posedge ref_clk) pwr.stb <= 1'b0;
		tick(4);
	endtask : key

	task automatic clr;
		@(posedge ref_clk) pwr <= '{1'b1, ibf_pkg::IBF_SEL_STATUS_CLR, 8'hff};
		@(posedge ref_clk) pwr.stb <= 1'b0;
		tick(2);
	endtask : clr

	// One framed byte; a read also leaves its byte unacknowledged
	task automatic go(input logic [7:0] d, input logic rd);
		@(posedge ref_clk) cmd <= '{1'b1, 1'b1, 1'b1, rd, rd, d};
		@(posedge ref_clk) cmd.go <= 1'b0;
		tick(1);
	endtask : go

	task automatic pulse_rec;
		@(posedge ref_clk) bus_recovery_request <= 1'b1;
		@(posedge ref_clk) bus_recovery_request <= 1'b0;
		tick(1);
	endtask : pulse_rec

	function automatic logic hit(input int w);
		case (w)
			0: return controller_ready_reg === 8'h00;
			1: return busy === 1'b0;
			default: return channel_status_reg[w - 2] === 1'b1;
		endcase
	endfunction : hit

	// Bounded wait: 0 ready, 1 idle, 2 and up a status bit
	task automatic wait_for(input int w);
		int i;
		for (i = 0; i < 4000 && !hit(w); i++)
			tick(1);
		chk({7'h00, hit(w)}, 8'h01);
	endtask : wait_for

	// Hang guard; the full run needs about 10000 cycles
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			bad_count++;
			give_verdict;
		end
	end

	initial begin
		nrst = 1'b0;
		rst_pin_n = 1'b1; // pin always driven
		pwr = '0;
		cmd = '0;
		cfg_timeout = 16'h0000;
		bus_recovery_request = 1'b0;
		hold_scl = 1'b0;
		glitch = 1'b0;
		tick(2);
		@(posedge ref_clk) nrst <= 1'b1;
		tick(1);
		chk(controller_ready_reg, 8'hff);
		go(8'h55, 1'b0);
		chk({7'h00, busy}, 8'h00);
		wait_for(0);
		// Own START and data edges must not count as faults
		go(8'h3c, 1'b0);
		chk({7'h00, busy}, 8'h01);
		wait_for(1);
		chk(channel_status_reg, 8'h08);
		clr;
		chk(channel_status_reg, 8'h00);
		// Bad START inside a data byte
		go(8'hff, 1'b0);
		tick(400);
		@(posedge ref_clk) glitch <= 1'b1;
		wait_for(2);
		chk({irq_flag, busy, pins.scl_oe, pins.sda_oe, channel_status_reg[3:0]}, 8'h81);
		@(posedge ref_clk) glitch <= 1'b0;
		key(ibf_pkg::IBF_SEL_CHAN_RST, 8'h00);
		chk(channel_status_reg, 8'h01);
		key(ibf_pkg::IBF_SEL_CHAN_RST, 8'h5a);
		chk(channel_status_reg, 8'h00);
		chk(controller_ready_reg, 8'h00);
		// Clock held low by the slave mid-transfer; limit above a normal low phase
		@(posedge ref_clk) cfg_timeout <= 16'h0100;
		go(8'h00, 1'b0);
		tick(100);
		@(posedge ref_clk) hold_scl <= 1'b1;
		wait_for(3);
		chk({irq_flag, channel_status_reg[1]}, 8'h03);
		wait_for(1);
		pulse_rec;
		chk({7'h00, busy}, 8'h00);
		@(posedge ref_clk) hold_scl <= 1'b0;
		@(posedge ref_clk) cfg_timeout <= 16'h0000;
		clr;
		pulse_rec;
		chk({7'h00, busy}, 8'h01);
		wait_for(1);
		// Read one byte from a released line, last byte not acknowledged
		go(8'h00, 1'b1);
		wait_for(1);
		chk(channel_status_reg, 8'h08);
		chk(rx_data, 8'hff);
		key(ibf_pkg::IBF_SEL_GLOBAL_RST, 8'h5a);
		chk(controller_ready_reg, 8'hff);
		wait_for(0);
		// Pin pulse just short of the minimum, then a long one
		@(posedge ref_clk) rst_pin_n <= 1'b0;
		tick(20);
		@(posedge ref_clk) rst_pin_n <= 1'b1;
		tick(4);
		chk(controller_ready_reg, 8'h00);
		@(posedge ref_clk) rst_pin_n <= 1'b0;
		tick(30);
		chk(controller_ready_reg, 8'hff);
		@(posedge ref_clk) rst_pin_n <= 1'b1;
		wait_for(0);
		give_verdict;
	end
endmodule : ibf_ctrl_test
